// *** verilog/ppgio_regs.svh ***
// Register indices, field layout, reset values and bus codes of the parallel port GPIO block.
`ifndef PPGIO_REGS_SVH
`define PPGIO_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PPGIO_IDX_ENABLE_LOW   30'h00004400
`define PPGIO_IDX_DIRECTION    30'h00004401
`define PPGIO_IDX_DATA         30'h00004402
`define PPGIO_IDX_BUS_SELECT   30'h00004410

// Field positions and widths.
`define PPGIO_LINES            46
`define PPGIO_CTRL_LINES       16
`define PPGIO_MUX_MODE_BIT     0

// Reset values.
`define PPGIO_ENABLE_RESET     16'h0000
`define PPGIO_DIRECTION_RESET  16'h0000
`define PPGIO_MUX_MODE_RESET   1'h1

// Bus answer codes.
`define PPGIO_RESP_OKAY        2'h0
`define PPGIO_RESP_SLVERR      2'h2

`endif

// *** verilog/ppgio_pkg.sv ***
// Types shared by the parallel port GPIO block.
package ppgio_pkg;

	typedef enum logic
	{
		MUX_HOST_GPIO,
		MUX_FULL_BUS
	} ppgio_mux_e;

	typedef enum logic [1:0]
	{
		WR_COLLECT,
		WR_RESP
	} ppgio_wr_e;

	typedef enum logic [1:0]
	{
		RD_IDLE,
		RD_RESP
	} ppgio_rd_e;

endpackage

// *** verilog/ppgio_pin_mux.sv ***
// Registered pin multiplexer between GPIO lines and the bus functions of the shared pins.
`timescale 1ns/100ps
`include "ppgio_regs.svh"

module ppgio_pin_mux
	import ppgio_pkg::*;
(
	// Clock and reset.
	input  wire logic                     clk,
	input  wire logic                     rstN,
	// Mode and GPIO side.
	input  wire ppgio_mux_e               muxMode,
	input  wire logic [15:0]              gpioOut,
	input  wire logic [15:0]              gpioOe,
	// Bus function side.
	input  wire logic [`PPGIO_LINES-1:0]  funcOut,
	input  wire logic [`PPGIO_LINES-1:0]  funcOe,
	output logic      [`PPGIO_LINES-1:0]  funcIn_q,
	// Pins.
	input  wire logic [`PPGIO_LINES-1:0]  pinIn,
	output logic      [`PPGIO_LINES-1:0]  pinOut_q,
	output logic      [`PPGIO_LINES-1:0]  pinOe_q
);

	logic [`PPGIO_LINES-1:0] pinOut_d;
	logic [`PPGIO_LINES-1:0] pinOe_d;
	logic [`PPGIO_LINES-1:0] funcIn_d;

	// Lines 16 to 45 have no enable register here, so in GPIO mode they stay inputs.
	always_comb
	begin
		pinOut_d = '0;
		pinOe_d  = '0;
		funcIn_d = '0;
		if (muxMode == MUX_FULL_BUS)
		begin
			pinOut_d = funcOut;
			pinOe_d  = funcOe;
			funcIn_d = pinIn;
		end
		else
		begin
			pinOut_d[15:0] = gpioOut;
			pinOe_d[15:0]  = gpioOe;
		end
	end

	always_ff @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pinOut_q <= '0;
			pinOe_q  <= '0;
			funcIn_q <= '0;
		end
		else
		begin
			pinOut_q <= pinOut_d;
			pinOe_q  <= pinOe_d;
			funcIn_q <= funcIn_d;
		end
	end

endmodule

// *** verilog/ppgio_top.sv ***
// Parallel port GPIO block with enable, direction, data and bus-select registers on AXI4-Lite.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "ppgio_regs.svh"

module ppgio_top
	import ppgio_pkg::*;
(
	// Clock and reset.
	input  wire logic                     mclk,
	input  wire logic                     nrst,
	// AXI4-Lite write address and data.
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              awaddr,
	input  wire logic                     wvalid,
	output logic                          wready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	// AXI4-Lite write response.
	output logic                          bvalid,
	input  wire logic                     bready,
	output logic      [1:0]               bresp,
	// AXI4-Lite read.
	input  wire logic                     arvalid,
	output logic                          arready,
	input  wire logic [31:0]              araddr,
	output logic                          rvalid,
	input  wire logic                     rready,
	output logic      [31:0]              rdata,
	output logic      [1:0]               rresp,
	// Bus function side of the shared pins.
	input  wire logic [`PPGIO_LINES-1:0]  funcOut,
	input  wire logic [`PPGIO_LINES-1:0]  funcOe,
	output logic      [`PPGIO_LINES-1:0]  funcIn,
	// Shared pins.
	input  wire logic [`PPGIO_LINES-1:0]  pinIn,
	output logic      [`PPGIO_LINES-1:0]  pinOut,
	output logic      [`PPGIO_LINES-1:0]  pinOe
);

	function automatic logic [29:0] regIndex(input logic [31:0] addr);
		return addr[31:2];
	endfunction

	function automatic logic isMapped(input logic [29:0] idx);
		return (idx == `PPGIO_IDX_ENABLE_LOW) || (idx == `PPGIO_IDX_DIRECTION) ||
			(idx == `PPGIO_IDX_DATA) || (idx == `PPGIO_IDX_BUS_SELECT);
	endfunction

	function automatic logic [15:0] applyStrb(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = d[7:0];
		if (strb[1])
			res[15:8] = d[15:8];
		return res;
	endfunction

	// Reset release through two flip-flops.
	logic rstMeta_q;
	logic rstN_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rstMeta_q <= 1'b0;
			rstN_q    <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN_q    <= rstMeta_q;
		end
	end

	// Write channel state.
	ppgio_wr_e   wrState_q, wrState_d;
	logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [31:0] wrAddr_q, wrAddr_d, wrData_q, wrData_d;
	logic [3:0]  wrStrb_q, wrStrb_d;
	logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        wrCommit;
	logic [29:0] wrIdx;

	assign wrCommit = (wrState_q == WR_COLLECT) && awHeld_q && wHeld_q;
	assign wrIdx    = regIndex(wrAddr_q);

	always_comb
	begin
		wrState_d = wrState_q;
		awHeld_d  = awHeld_q;
		wHeld_d   = wHeld_q;
		wrAddr_d  = wrAddr_q;
		wrData_d  = wrData_q;
		wrStrb_d  = wrStrb_q;
		awready_d = awready_q;
		wready_d  = wready_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		case (wrState_q)
			WR_COLLECT:
			begin
				if (awvalid && awready_q)
				begin
					awHeld_d  = 1'b1;
					wrAddr_d  = awaddr;
					awready_d = 1'b0;
				end
				if (wvalid && wready_q)
				begin
					wHeld_d  = 1'b1;
					wrData_d = wdata;
					wrStrb_d = wstrb;
					wready_d = 1'b0;
				end
				if (wrCommit)
				begin
					awHeld_d  = 1'b0;
					wHeld_d   = 1'b0;
					bvalid_d  = 1'b1;
					bresp_d   = isMapped(wrIdx) ? `PPGIO_RESP_OKAY : `PPGIO_RESP_SLVERR;
					wrState_d = WR_RESP;
				end
			end
			WR_RESP:
			begin
				if (bready)
				begin
					bvalid_d  = 1'b0;
					awready_d = 1'b1;
					wready_d  = 1'b1;
					wrState_d = WR_COLLECT;
				end
			end
			default:
			begin
				wrState_d = WR_COLLECT;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			wrState_q <= WR_COLLECT;
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			wrAddr_q  <= 32'h0;
			wrData_q  <= 32'h0;
			wrStrb_q  <= 4'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `PPGIO_RESP_OKAY;
		end
		else
		begin
			wrState_q <= wrState_d;
			awHeld_q  <= awHeld_d;
			wHeld_q   <= wHeld_d;
			wrAddr_q  <= wrAddr_d;
			wrData_q  <= wrData_d;
			wrStrb_q  <= wrStrb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// Control registers.
	logic [15:0] enable_q, enable_d, dir_q, dir_d, data_q, data_d;
	ppgio_mux_e  muxMode_q, muxMode_d;

	// Input lines follow the pins every cycle, so the data register holds the pin levels
	// from the first edge after reset; only output lines keep written values.
	always_comb
	begin
		enable_d  = enable_q;
		dir_d     = dir_q;
		muxMode_d = muxMode_q;
		data_d    = (data_q & dir_q) | (pinIn[15:0] & ~dir_q);
		if (wrCommit)
		begin
			case (wrIdx)
				`PPGIO_IDX_ENABLE_LOW: enable_d = applyStrb(enable_q, wrData_q, wrStrb_q);
				`PPGIO_IDX_DIRECTION:  dir_d = applyStrb(dir_q, wrData_q, wrStrb_q);
				`PPGIO_IDX_DATA:       data_d = (applyStrb(data_q, wrData_q, wrStrb_q) & dir_q) |
					(pinIn[15:0] & ~dir_q);
				`PPGIO_IDX_BUS_SELECT:
				begin
					if (wrStrb_q[0])
						muxMode_d = ppgio_mux_e'(wrData_q[`PPGIO_MUX_MODE_BIT]);
				end
				default:
				begin
					enable_d = enable_q;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			enable_q  <= `PPGIO_ENABLE_RESET;
			dir_q     <= `PPGIO_DIRECTION_RESET;
			data_q    <= 16'h0000;
			muxMode_q <= ppgio_mux_e'(`PPGIO_MUX_MODE_RESET);
		end
		else
		begin
			enable_q  <= enable_d;
			dir_q     <= dir_d;
			data_q    <= data_d;
			muxMode_q <= muxMode_d;
		end
	end

	// Read channel.
	ppgio_rd_e   rdState_q, rdState_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [29:0] rdIdx;

	assign rdIdx = regIndex(araddr);

	always_comb
	begin
		rdState_d = rdState_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		case (rdState_q)
			RD_IDLE:
			begin
				if (arvalid && arready_q)
				begin
					arready_d = 1'b0;
					rvalid_d  = 1'b1;
					rresp_d   = isMapped(rdIdx) ? `PPGIO_RESP_OKAY : `PPGIO_RESP_SLVERR;
					case (rdIdx)
						`PPGIO_IDX_ENABLE_LOW: rdata_d = {16'h0000, enable_q};
						`PPGIO_IDX_DIRECTION:  rdata_d = {16'h0000, dir_q};
						`PPGIO_IDX_DATA:       rdata_d = {16'h0000, data_q};
						`PPGIO_IDX_BUS_SELECT: rdata_d = {31'h0, muxMode_q};
						default:               rdata_d = 32'h0;
					endcase
					rdState_d = RD_RESP;
				end
			end
			RD_RESP:
			begin
				if (rready)
				begin
					rvalid_d  = 1'b0;
					arready_d = 1'b1;
					rdState_d = RD_IDLE;
				end
			end
			default:
			begin
				rdState_d = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstN_q)
	begin
		if (!rstN_q)
		begin
			rdState_q <= RD_IDLE;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= `PPGIO_RESP_OKAY;
		end
		else
		begin
			rdState_q <= rdState_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	// In GPIO mode the enable bit alone gates the driver of lines 0 to 15; the direction bit only steers the data register.
	ppgio_pin_mux u_pin_mux
	(
		.clk      (mclk),
		.rstN     (rstN_q),
		.muxMode  (muxMode_q),
		.gpioOut  (data_q),
		.gpioOe   (enable_q),
		.funcOut  (funcOut),
		.funcOe   (funcOe),
		.funcIn_q (funcIn),
		.pinIn    (pinIn),
		.pinOut_q (pinOut),
		.pinOe_q  (pinOe)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN_q);

	chk_mux_overrides: assert property ((muxMode_q == MUX_FULL_BUS) |=>
		pinOe == $past(funcOe))
		else $error("Enable bits reached the pins while the bus function was selected.");
	chk_gpio_map_oe: assert property ((muxMode_q == MUX_HOST_GPIO) |=>
		(pinOe[`PPGIO_LINES-1:16] == '0) && (pinOut[15:0] == $past(data_q)))
		else $error("GPIO mode pin mapping is wrong.");
	chk_bus_func_in: assert property ((muxMode_q == MUX_FULL_BUS) |=>
		funcIn == $past(pinIn))
		else $error("Bus function input not passed from the pins.");
	chk_en_off_drv: assert property ((muxMode_q == MUX_HOST_GPIO) |=>
		(pinOe[15:0] & ~$past(enable_q)) == 16'h0000)
		else $error("Driver on for a line whose enable bit is clear.");
	chk_en_on_drv: assert property ((muxMode_q == MUX_HOST_GPIO) |=>
		(pinOe[15:0] & $past(enable_q)) == $past(enable_q))
		else $error("Driver off for a line whose enable bit is set.");
	// The answer rises on the same edge as the register; bready may end it one edge later.
	chk_enable_write: assert property ((wrCommit && wrIdx == `PPGIO_IDX_ENABLE_LOW &&
		wrStrb_q[1:0] == 2'h3) |=> (enable_q == $past(wrData_q[15:0])) && bvalid_q)
		else $error("Enable register write not stored.");
	chk_mode_stable: assert property (!wrCommit |=> $stable(muxMode_q))
		else $error("Mux mode changed without a write.");
	chk_input_follow: assert property (1'b1 |=>
		(data_q & ~$past(dir_q)) == ($past(pinIn[15:0]) & ~$past(dir_q)))
		else $error("Input line data does not follow the pin.");
	chk_data_read: assert property ((arvalid && arready_q && rdIdx == `PPGIO_IDX_DATA) |=>
		rvalid_q && rdata_q == {16'h0000, $past(data_q)})
		else $error("Data register read does not return line state.");

	cov_write_done: cover property (bvalid_q && bready && bresp_q == `PPGIO_RESP_OKAY);
	cov_read_done: cover property (rvalid_q && rready);
	cov_gpio_drive: cover property ((muxMode_q == MUX_HOST_GPIO) && (enable_q != 16'h0000) ##1 pinOe[0]);

endmodule

// *** verif/ppgio_pin_partner.sv ***
// Model of the external circuits that share the parallel and host pins.
`timescale 1ns/100ps
`include "ppgio_regs.svh"

module ppgio_pin_partner
(
	// Level that the outside circuit holds on a pin left undriven.
	input  wire logic [`PPGIO_LINES-1:0] extLevel,
	// Drive from the block.
	input  wire logic [`PPGIO_LINES-1:0] pinOut,
	input  wire logic [`PPGIO_LINES-1:0] pinOe,
	// Resolved wire level fed back to the block.
	output logic      [`PPGIO_LINES-1:0] pinIn
);
	// A driven pin follows the block; an undriven one shows the outside level.
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench of the parallel port GPIO block.
`timescale 1ns/100ps
`include "ppgio_regs.svh"

module tb_top;
	logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [45:0] funcOut, funcOe, funcIn, pinIn, pinOut, pinOe, extLevel;
	logic [31:0] v;
	logic [15:0] en, dat;
	int          failures, totalChecks, cycles;

	ppgio_top i_ppgio_top (.mclk(mclk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .funcOut(funcOut), .funcOe(funcOe),
		.funcIn(funcIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

	ppgio_pin_partner i_ppgio_pin_partner (.extLevel(extLevel), .pinOut(pinOut),
		.pinOe(pinOe), .pinIn(pinIn));

	always #10 mclk = ~mclk;

	task automatic end_of_test();
		$display("checks %0d, failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A hang is cut short after a generous bound on the whole run.
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			end_of_test();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		totalChecks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [29:0] idx, input logic [15:0] val,
		input logic [3:0] strb = 4'hf);
		@(posedge mclk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {16'h0000, val};
		wstrb   <= strb;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		resp   = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [29:0] idx, output logic [31:0] val);
		@(posedge mclk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		val    = rdata;
		resp   = rresp;
		rready <= 1'b0;
	endtask

	function automatic logic [45:0] rnd46();
		logic [63:0] t;
		t = {$urandom(), $urandom()};
		return t[45:0];
	endfunction

	// Input lines read the pin, output lines keep the written value.
	function automatic logic [15:0] expDat(logic [15:0] dir, logic [15:0] w, logic [45:0] e);
		return (dir & w) | (~dir & e[15:0]);
	endfunction

	initial
	begin
		{mclk, nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr, wstrb, funcOut, funcOe, extLevel} = '0;
		void'($urandom(32'hb364));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		// Input lines take the pin levels from the first edges after reset.
		extLevel <= rnd46();
		rd(`PPGIO_IDX_DATA, v);
		check({v, resp}, {16'h0000, extLevel[15:0], `PPGIO_RESP_OKAY}, "data after reset");
		rd(`PPGIO_IDX_ENABLE_LOW, v);
		check(v, 32'h0, "enable reset value");
		rd(`PPGIO_IDX_BUS_SELECT, v);
		check(v[0], 1'b1, "mux mode reset value");
		// Full bus mode: enable bits must not take over the pins.
		for (int i = 0; i < 4; i++)
		begin
			funcOut  <= rnd46();
			funcOe   <= rnd46();
			extLevel <= rnd46();
			en = (i == 0) ? 16'hffff : 16'($urandom());
			wr(`PPGIO_IDX_DIRECTION, en);
			wr(`PPGIO_IDX_ENABLE_LOW, en);
			repeat (3) @(posedge mclk);
			check(pinOe, funcOe, "bus mode pin enable");
			check(pinOut & pinOe, funcOut & funcOe, "bus mode pin drive");
			check(funcIn, pinIn, "bus mode pin input");
			rd(`PPGIO_IDX_ENABLE_LOW, v);
			check(v, {16'h0000, en}, "enable read back");
		end
		wr(`PPGIO_IDX_BUS_SELECT, 16'h0000);
		check(resp, `PPGIO_RESP_OKAY, "bus select write answer");
		rd(`PPGIO_IDX_BUS_SELECT, v);
		check(v, 32'h0, "bus select read back");
		// GPIO mode: enable gates the driver, direction picks the data source.
		for (int i = 0; i < 8; i++)
		begin
			en  = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom());
			dat = 16'($urandom());
			funcOe   <= rnd46();
			extLevel <= rnd46();
			wr(`PPGIO_IDX_ENABLE_LOW, en);
			wr(`PPGIO_IDX_DIRECTION, en);
			wr(`PPGIO_IDX_DATA, dat);
			repeat (3) @(posedge mclk);
			check(pinOe, {30'h0, en}, "gpio pin enable");
			check(pinOut & pinOe, {30'h0, dat & en}, "gpio pin drive");
			check(funcIn, 46'h0, "bus input in gpio mode");
			rd(`PPGIO_IDX_DATA, v);
			check(v, {16'h0000, expDat(en, dat, extLevel)}, "data read");
			rd(`PPGIO_IDX_DIRECTION, v);
			check({v, resp}, {16'h0000, en, `PPGIO_RESP_OKAY}, "direction read back");
		end
		wr(30'h00000010, 16'hffff);
		check(resp, `PPGIO_RESP_SLVERR, "unmapped write answer");
		rd(30'h00000010, v);
		check({v, resp}, {32'h0, `PPGIO_RESP_SLVERR}, "unmapped read answer");
		// A strobe on the high byte alone leaves the low byte of the enable register alone.
		wr(`PPGIO_IDX_ENABLE_LOW, 16'h0000, 4'h2);
		rd(`PPGIO_IDX_ENABLE_LOW, v);
		check(v, {24'h000000, en[7:0]}, "enable byte strobe");
		wr(`PPGIO_IDX_ENABLE_LOW, 16'hffff);
		wr(`PPGIO_IDX_BUS_SELECT, 16'h0001);
		repeat (3) @(posedge mclk);
		check(pinOe, funcOe, "bus mode restored");
		end_of_test();
	end
endmodule
